// ===== logic/sfia_pkg.sv
// Purpose: shared constants for the fabric indirect access port
// Assumes: 32-bit host register port, 16-bit fabric index
// Notes:   offsets are byte addresses
package sfia_pkg;
  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [11:0] SFIA_DATA_OFS = 12'h01ac;
  localparam logic [11:0] SFIA_CMD_OFS  = 12'h01b0;
  // ----------------------------------------------------------------
  // command field positions
  // ----------------------------------------------------------------
  localparam int SFIA_PEND_BIT = 31;
  localparam int SFIA_DIR_BIT  = 30;
  localparam int SFIA_INC_BIT  = 29;
  localparam int SFIA_DEC_BIT  = 28;
  localparam int SFIA_BE_LO    = 16;
  localparam int SFIA_BE_HI    = 19;
  localparam int SFIA_IDX_HI   = 15;
  // ----------------------------------------------------------------
  // reset values and the index step
  // ----------------------------------------------------------------
  localparam logic [31:0] SFIA_DATA_RST = 32'h0000_0000;
  localparam logic [15:0] SFIA_IDX_RST  = 16'h0000;
  localparam logic [3:0]  SFIA_BE_RST   = 4'h0;
  localparam logic [15:0] SFIA_IDX_ONE  = 16'h0001;
endpackage

// ===== logic/sfia_fabric_if.sv
// Purpose: request/acknowledge carrier toward the fabric register set
// Assumes: one clock domain
// Notes:   request held until ack
`timescale 1ns/10ps
`default_nettype none
interface sfia_fabric_if;
  logic        req;
  logic        rd;
  logic [15:0] index;
  logic [31:0] wdata;
  logic [3:0]  be;
  logic        ack;
  logic [31:0] rdata;
  modport master (output req, output rd, output index, output wdata, output be,
                  input ack, input rdata);
  modport slave  (input req, input rd, input index, input wdata, input be,
                  output ack, output rdata);
endinterface
`default_nettype wire

// ===== logic/sfia_req_port.sv
// Purpose: holds one fabric request until acknowledged
// Assumes: ack is a one-cycle pulse from same-clock logic
// Notes:   done pulses in the cycle after ack with read data captured
`timescale 1ns/10ps
`default_nettype none
module sfia_req_port
  import sfia_pkg::*;
(
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  // launch side
  input  wire logic        start_in,
  input  wire logic        rd_in,
  input  wire logic [15:0] index_in,
  input  wire logic [31:0] wdata_in,
  input  wire logic [3:0]  be_in,
  output logic             done_out,
  output logic [31:0]      rdata_out,
  // fabric side
  sfia_fabric_if.master    fab
);
  logic        req_reg;
  logic        rd_reg;
  logic [15:0] index_reg;
  logic [31:0] wdata_reg;
  logic [3:0]  be_reg;

  assign fab.req   = req_reg;
  assign fab.rd    = rd_reg;
  assign fab.index = index_reg;
  assign fab.wdata = wdata_reg;
  assign fab.be    = be_reg;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      req_reg <= 1'b0;
    end else if (start_in) begin
      req_reg <= 1'b1;
    end else if (fab.ack) begin
      req_reg <= 1'b0; // R15
    end
  end

  // request fields frozen while outstanding
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rd_reg    <= 1'b0;
      index_reg <= SFIA_IDX_RST;
      wdata_reg <= SFIA_DATA_RST;
      be_reg    <= SFIA_BE_RST;
    end else if (start_in) begin
      rd_reg    <= rd_in; // R15
      index_reg <= index_in;
      wdata_reg <= wdata_in;
      be_reg    <= be_in; // R14
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      done_out  <= 1'b0;
      rdata_out <= SFIA_DATA_RST;
    end else begin
      done_out <= req_reg && fab.ack;
      if (req_reg && fab.ack && rd_reg) begin
        rdata_out <= fab.rdata; // R15
      end
    end
  end
endmodule
`default_nettype wire

// ===== logic/sfia_top.sv
// Purpose: indirect access port from host registers to fabric registers
// Assumes: single clock; fabric acks each request with one-cycle pulse
// Notes:   host port never stalls; read data valid the cycle after read strobe
//
// Overview of operation
// R01: writing 1 to command bit 31 starts one fabric access at the index, direction per bit 30.
// R02: the pending bit stays set during the access, self-clears at the end, and resets to 0.
// R03: read results land in the data register no later than the pending bit clearing.
// R04: the host leaves command and data alone while the pending bit is set.
// R05: bit 30 selects direction, 0 write and 1 read, resetting to 0.
// R06: a data read returns fabric data when direction is read, else the host-written word.
// R07: the data register is a 32-bit read/write word resetting to zero.
// R08: the fabric index is command bits 15:0.
// R09: with step-up set a data write launches an access and the index rises after it completes.
// R10: with step-up set a data read raises the index and launches the next read.
// R11: software clears stepping before the final data read of a sequence.
// R12: step-up wins over step-down; step-up resets to 0.
// R13: step-down at bit 28 works like step-up but lowers the index.
// R14: byte enables at bits 19:16 gate written bytes, enable 3 for bits 31:24.
// R15: the fabric request is held until acknowledged, then read data is caught and pending clears.
`timescale 1ns/10ps
`default_nettype none
module sfia_top
  import sfia_pkg::*;
#(
  // fabric geometry; the 32-bit command word pins both to these values
  parameter int INDEX_W = 16,
  parameter int LANES   = 4
)
(
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  // host register port
  input  wire logic [11:0] reg_addr_in,
  input  wire logic [31:0] reg_wdata_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  output logic [31:0]      reg_rdata_out,
  // fabric register set
  output logic             fab_req_out,
  output logic             fab_rd_out,
  output logic [15:0]      fab_index_out,
  output logic [31:0]      fab_wdata_out,
  output logic [3:0]       fab_be_out,
  input  wire logic        fab_ack_in,
  input  wire logic [31:0] fab_rdata_in
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {SFIA_IDLE, SFIA_BUSY, SFIA_STEP} sfia_state_t;

  sfia_state_t state_reg;
  logic        pending_reg;
  logic        dir_reg;
  logic        up_reg;
  logic        down_reg;
  logic [3:0]  be_reg;
  logic [15:0] index_reg;
  logic [31:0] host_word_reg;
  logic [31:0] fab_word_reg;
  logic        auto_wr_reg;

  logic        start;
  logic [15:0] start_index;
  logic        done;
  logic [31:0] rdata;
  logic        wr_data;
  logic        wr_cmd;
  logic        rd_data;
  logic        rd_cmd;
  logic        stepping;
  logic [15:0] index_step;
  logic        start_rd;
  logic [3:0]  start_be;
  logic [31:0] start_wdata;
  logic [31:0] cmd_word;

  sfia_fabric_if fab ();

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  // the host sees one fixed command word, so the geometry cannot grow
  if (INDEX_W != SFIA_IDX_HI + 1) begin : g_bad_index
    $error("index width must match the command index field");
  end
  if (LANES != SFIA_BE_HI - SFIA_BE_LO + 1) begin : g_bad_lanes
    $error("lane count must match the byte lane field");
  end
  if (SFIA_BE_LO <= SFIA_IDX_HI) begin : g_bad_lane_pos
    $error("byte lane field overlaps the index field");
  end
  if (SFIA_DEC_BIT <= SFIA_BE_HI) begin : g_bad_mode_pos
    $error("mode bits overlap the byte lane field");
  end

  // ----------------------------------------------------------------
  // host decode
  // ----------------------------------------------------------------
  // only exact word addresses hit; anything else reads zero and is ignored
  assign wr_data  = reg_wr_in && (reg_addr_in == SFIA_DATA_OFS);
  assign wr_cmd   = reg_wr_in && (reg_addr_in == SFIA_CMD_OFS);
  assign rd_data  = reg_rd_in && (reg_addr_in == SFIA_DATA_OFS);
  assign rd_cmd   = reg_rd_in && (reg_addr_in == SFIA_CMD_OFS);
  assign stepping = up_reg || down_reg;

  // ----------------------------------------------------------------
  // index stepping
  // ----------------------------------------------------------------
  // step-up has precedence; the index wraps at both ends of its range
  always_comb begin
    if (up_reg) begin
      index_step = index_reg + SFIA_IDX_ONE; // R12
    end else begin
      index_step = index_reg - SFIA_IDX_ONE; // R13
    end
  end

  // ----------------------------------------------------------------
  // launch decision
  // ----------------------------------------------------------------
  // idle-only launches: a strobe while pending is ignored, host must wait
  always_comb begin
    start       = 1'b0;
    start_index = index_reg;
    if (state_reg == SFIA_IDLE) begin
      if (wr_cmd && reg_wdata_in[SFIA_PEND_BIT]) begin
        start       = 1'b1; // R01
        start_index = reg_wdata_in[SFIA_IDX_HI:0]; // R08
      end else if (wr_data && stepping) begin
        start = 1'b1; // R09
      end else if (rd_data && stepping) begin
        start       = 1'b1; // R10
        start_index = index_step; // R10 R13
      end
    end
  end

  // request fields: a command write brings its own direction and lanes,
  // a data write always goes out as a fabric write of the fresh word,
  // and a stepping data read reuses what the command register holds
  always_comb begin
    start_rd    = dir_reg;
    start_be    = be_reg;
    start_wdata = host_word_reg;
    if (wr_cmd) begin
      start_rd = reg_wdata_in[SFIA_DIR_BIT]; // R05
      start_be = reg_wdata_in[SFIA_BE_HI:SFIA_BE_LO]; // R14
    end else if (wr_data) begin
      start_rd    = 1'b0; // R09
      start_wdata = reg_wdata_in;
    end
  end

  sfia_req_port u_req (
    .clk_in    (clk_in),
    .rst_n_in  (rst_n_in),
    .start_in  (start),
    .rd_in     (start_rd),
    .index_in  (start_index),
    .wdata_in  (start_wdata),
    .be_in     (start_be),
    .done_out  (done),
    .rdata_out (rdata),
    .fab       (fab)
  );

  assign fab.ack   = fab_ack_in;
  assign fab.rdata = fab_rdata_in;

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  // pending mirrors the state: set on launch, cleared on the idle return
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_reg   <= SFIA_IDLE;
      pending_reg <= 1'b0;
      auto_wr_reg <= 1'b0;
    end else begin
      case (state_reg)
        SFIA_IDLE: begin
          if (start) begin
            state_reg   <= SFIA_BUSY;
            pending_reg <= 1'b1; // R02
            auto_wr_reg <= wr_data;
          end
        end
        SFIA_BUSY: begin
          if (done) begin
            // read data is latched by now, so pending clears in step
            if (auto_wr_reg) begin
              state_reg <= SFIA_STEP;
            end else begin
              state_reg   <= SFIA_IDLE;
              pending_reg <= 1'b0; // R02 R03
            end
          end
        end
        SFIA_STEP: begin
          // one extra cycle after an automatic write: the index steps on the
          // same edge pending clears, so a poll never sees a stale index
          state_reg   <= SFIA_IDLE;
          pending_reg <= 1'b0; // R09
          auto_wr_reg <= 1'b0;
        end
        default: begin
          state_reg   <= SFIA_IDLE;
          pending_reg <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // command register fields
  // ----------------------------------------------------------------
  // fields only move while idle so an access in flight keeps its setup
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      dir_reg  <= 1'b0;
      up_reg   <= 1'b0;
      down_reg <= 1'b0;
      be_reg   <= SFIA_BE_RST;
    end else if (wr_cmd && state_reg == SFIA_IDLE) begin
      dir_reg  <= reg_wdata_in[SFIA_DIR_BIT]; // R05
      up_reg   <= reg_wdata_in[SFIA_INC_BIT]; // R12
      down_reg <= reg_wdata_in[SFIA_DEC_BIT]; // R13
      be_reg   <= reg_wdata_in[SFIA_BE_HI:SFIA_BE_LO]; // R14
    end
  end

  // a stepping data read moves the index at the launch edge, so the read
  // it starts already targets the next register
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      index_reg <= SFIA_IDX_RST;
    end else if (state_reg == SFIA_STEP) begin
      index_reg <= index_step; // R09 R13
    end else if (state_reg == SFIA_IDLE) begin
      if (wr_cmd) begin
        index_reg <= reg_wdata_in[SFIA_IDX_HI:0]; // R08
      end else if (rd_data && stepping) begin
        index_reg <= index_step; // R10
      end
    end
  end

  // ----------------------------------------------------------------
  // data holding words
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      host_word_reg <= SFIA_DATA_RST; // R07
    end else if (wr_data && state_reg == SFIA_IDLE) begin
      host_word_reg <= reg_wdata_in; // R07
    end
  end

  // only a fabric read refreshes this word, so a write leaves the last
  // result readable once the direction is switched back to read
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      fab_word_reg <= SFIA_DATA_RST;
    end else if (done && fab_rd_out) begin
      fab_word_reg <= rdata; // R03
    end
  end

  // ----------------------------------------------------------------
  // read back
  // ----------------------------------------------------------------
  // reserved bits 27:20 stay zero
  always_comb begin
    cmd_word                        = SFIA_DATA_RST;
    cmd_word[SFIA_PEND_BIT]         = pending_reg; // R02
    cmd_word[SFIA_DIR_BIT]          = dir_reg; // R05
    cmd_word[SFIA_INC_BIT]          = up_reg; // R12
    cmd_word[SFIA_DEC_BIT]          = down_reg; // R13
    cmd_word[SFIA_BE_HI:SFIA_BE_LO] = be_reg; // R14
    cmd_word[SFIA_IDX_HI:0]         = index_reg; // R08
  end

  // the word stands for one cycle only, then the port returns to zero
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      reg_rdata_out <= SFIA_DATA_RST;
    end else if (rd_data) begin
      reg_rdata_out <= dir_reg ? fab_word_reg : host_word_reg; // R06
    end else if (rd_cmd) begin
      reg_rdata_out <= cmd_word;
    end else begin
      reg_rdata_out <= SFIA_DATA_RST;
    end
  end

  // fabric outputs straight from the request port flops
  assign fab_req_out   = fab.req;
  assign fab_rd_out    = fab.rd;
  assign fab_index_out = fab.index;
  assign fab_wdata_out = fab.wdata;
  assign fab_be_out    = fab.be;
endmodule
`default_nettype wire

// ===== test/sfia_fabric_model.sv
// Purpose: behavioural fabric register set answering the indirect port
// Assumes: one clock; sixteen words, picked by the low index bits
// Notes:   wait_in sets the ack delay so prompt and slow answers are both seen
`timescale 1ns/10ps
`default_nettype none
module sfia_fabric_model (
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  // request side
  input  wire logic        req_in,
  input  wire logic        rd_in,
  input  wire logic [15:0] index_in,
  input  wire logic [31:0] wdata_in,
  input  wire logic [3:0]  be_in,
  input  wire logic [3:0]  wait_in,
  // answer side
  output logic             ack_out,
  output logic [31:0]      rdata_out
);
  logic [31:0] mem [16];
  logic [3:0]  cnt_reg;
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ack_out <= 1'b0;
      cnt_reg <= 4'h0;
      for (int i = 0; i < 16; i++) mem[i] <= 32'h0000_0000;
    end else if (req_in && !ack_out && cnt_reg == wait_in) begin
      ack_out <= 1'b1;
      cnt_reg <= 4'h0;
      for (int b = 0; b < 4; b++) begin
        if (!rd_in && be_in[b]) mem[index_in[3:0]][8*b +: 8] <= wdata_in[8*b +: 8];
      end
    end else begin
      ack_out <= 1'b0;
      if (req_in && !ack_out) cnt_reg <= cnt_reg + 4'h1;
    end
  end
  // outside the ack cycle the data is junk, never the last good word
  assign rdata_out = ack_out ? mem[index_in[3:0]] : ~mem[index_in[3:0]];
endmodule
`default_nettype wire

// ===== test/sfia_monitor.sv
// Purpose: port checker for the fabric indirect access port
// Assumes: fabric acks with a one-cycle pulse
// Notes:   bound into sfia_top
`timescale 1ns/10ps
`default_nettype none
module sfia_monitor
  import sfia_pkg::*;
(
  input wire logic        clk_in,
  input wire logic        rst_n_in,
  input wire logic [11:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic        reg_wr_in,
  input wire logic        reg_rd_in,
  input wire logic [31:0] reg_rdata_out,
  input wire logic        fab_req_out,
  input wire logic        fab_rd_out,
  input wire logic [15:0] fab_index_out,
  input wire logic [31:0] fab_wdata_out,
  input wire logic [3:0]  fab_be_out,
  input wire logic        fab_ack_in,
  input wire logic [31:0] fab_rdata_in
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  logic [31:0] wd_q;
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) wd_q <= 32'h0000_0000;
    else wd_q <= reg_wdata_in;
  end
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  property p_hold;
    fab_req_out && !fab_ack_in |=> fab_req_out && $stable(fab_index_out)
      && $stable(fab_rd_out) && $stable(fab_be_out) && $stable(fab_wdata_out);
  endproperty
  a_hold: assert property (p_hold) else $error("request changed before ack");
  property p_drop;
    fab_ack_in |=> !fab_req_out;
  endproperty
  a_drop: assert property (p_drop) else $error("request held after ack");
  property p_launch;
    reg_wr_in && reg_addr_in == SFIA_CMD_OFS && reg_wdata_in[31] && !fab_req_out
      && !$past(fab_ack_in) && !$past(fab_ack_in, 2) && !$past(fab_ack_in, 3)
      |=> fab_req_out && fab_rd_out == wd_q[30] && fab_index_out == wd_q[15:0]
      && fab_be_out == wd_q[19:16];
  endproperty
  a_launch: assert property (p_launch) else $error("command did not launch");
  property p_quiet;
    !$past(reg_rd_in) |-> reg_rdata_out == 32'h0000_0000;
  endproperty
  a_quiet: assert property (p_quiet) else $error("read data outside read slot");
  property p_unmapped;
    reg_rd_in && reg_addr_in != SFIA_CMD_OFS && reg_addr_in != SFIA_DATA_OFS
      |=> reg_rdata_out == 32'h0000_0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_cause;
    $rose(fab_req_out) |-> $past(reg_wr_in) || $past(reg_rd_in);
  endproperty
  a_cause: assert property (p_cause) else $error("request without host access");
  property p_gap;
    $fell(fab_req_out) |=> !fab_req_out;
  endproperty
  a_gap: assert property (p_gap) else $error("request before pending cleared");
  property p_auto_wr;
    $rose(fab_req_out) && $past(reg_wr_in) && $past(reg_addr_in) == SFIA_DATA_OFS
      |-> !fab_rd_out && fab_wdata_out == $past(reg_wdata_in);
  endproperty
  a_auto_wr: assert property (p_auto_wr) else $error("auto write word wrong");
  c_rd: cover property (fab_ack_in && fab_rd_out);
  c_wr: cover property (fab_ack_in && !fab_rd_out);
  c_auto_rd: cover property ($rose(fab_req_out) && $past(reg_rd_in));
endmodule
bind sfia_top sfia_monitor u_mon (.clk_in(clk_in), .rst_n_in(rst_n_in),
  .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
  .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .fab_req_out(fab_req_out),
  .fab_rd_out(fab_rd_out), .fab_index_out(fab_index_out), .fab_wdata_out(fab_wdata_out),
  .fab_be_out(fab_be_out), .fab_ack_in(fab_ack_in), .fab_rdata_in(fab_rdata_in));
`default_nettype wire

// ===== test/switch_fabric_indirect_access_test.sv
// Purpose: register-level test of the fabric indirect access port
// Assumes: fabric model holds sixteen words
// Notes:   busy is polled with a bounded loop
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin errors++; \
  $display("FAIL %s exp %h got %h", n, e, g); end end
module switch_fabric_indirect_access_test
  import sfia_pkg::*;
;
  logic clk_in = 1'b0, rst_n_in = 1'b0, wr = 1'b0, rd = 1'b0, req, frd, ack;
  logic [11:0] addr = 12'h000;
  logic [31:0] wdata = 32'h0000_0000, rdata, fwd, frdata;
  logic [15:0] fidx;
  logic [3:0]  fbe, wait_q = 4'h0;
  int errors = 0, tests_run = 0;
  always #12.5 clk_in = ~clk_in;
  sfia_top dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
    .fab_req_out(req), .fab_rd_out(frd), .fab_index_out(fidx), .fab_wdata_out(fwd),
    .fab_be_out(fbe), .fab_ack_in(ack), .fab_rdata_in(frdata));
  sfia_fabric_model u_fab (.clk_in(clk_in), .rst_n_in(rst_n_in), .req_in(req),
    .rd_in(frd), .index_in(fidx), .wdata_in(fwd), .be_in(fbe), .wait_in(wait_q),
    .ack_out(ack), .rdata_out(frdata));
  function automatic logic [31:0] cmd(logic go, logic dir, logic inc, logic dec,
                                      logic [3:0] be, logic [15:0] idx);
    return {go, dir, inc, dec, 8'h00, be, idx};
  endfunction
  task automatic wr_reg(logic [11:0] a, logic [31:0] d);
    @(posedge clk_in);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_in);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(logic [11:0] a, output logic [31:0] d);
    @(posedge clk_in);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_in);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic chk_rd(string n, logic [11:0] a, logic [31:0] e);
    logic [31:0] d;
    rd_reg(a, d);
    `CHK(n, e, d)
  endtask
  // the host polls only the command register until pending clears
  task automatic wait_idle();
    logic [31:0] d;
    for (int i = 0; i < 50; i++) begin
      rd_reg(SFIA_CMD_OFS, d);
      if (d[31] === 1'b0) return;
    end
    errors++;
    $display("FAIL wait_idle exp 0 got 1");
    conclude();
  endtask
  task automatic conclude();
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge clk_in);
    rst_n_in <= 1'b1;
    chk_rd("cmd_rst", SFIA_CMD_OFS, 32'h0000_0000);
    chk_rd("data_rst", SFIA_DATA_OFS, 32'h0000_0000);
    chk_rd("unmapped", 12'h01a8, 32'h0000_0000);
    wr_reg(SFIA_DATA_OFS, 32'h1234_5678);
    wr_reg(SFIA_CMD_OFS, cmd(1, 0, 0, 0, 4'hf, 16'h0005));
    wait_idle();
    wr_reg(SFIA_CMD_OFS, cmd(1, 1, 0, 0, 4'hf, 16'h0005));
    wait_idle();
    chk_rd("rd5", SFIA_DATA_OFS, 32'h1234_5678);
    wait_q <= 4'h5;
    wr_reg(SFIA_DATA_OFS, 32'haabb_ccdd);
    wr_reg(SFIA_CMD_OFS, cmd(1, 0, 0, 0, 4'h5, 16'h0005));
    chk_rd("busy", SFIA_CMD_OFS, cmd(1, 0, 0, 0, 4'h5, 16'h0005));
    wait_idle();
    chk_rd("dir0", SFIA_DATA_OFS, 32'haabb_ccdd);
    wr_reg(SFIA_CMD_OFS, cmd(1, 1, 0, 0, 4'h0, 16'h0005));
    wait_idle();
    chk_rd("be", SFIA_DATA_OFS, 32'h12bb_56dd);
    wr_reg(SFIA_CMD_OFS, cmd(0, 0, 1, 0, 4'hf, 16'h0008));
    wr_reg(SFIA_DATA_OFS, 32'h0a0a_0001);
    wait_idle();
    wr_reg(SFIA_DATA_OFS, 32'h0b0b_0002);
    wait_idle();
    chk_rd("inc", SFIA_CMD_OFS, cmd(0, 0, 1, 0, 4'hf, 16'h000a));
    wr_reg(SFIA_CMD_OFS, cmd(0, 0, 1, 1, 4'hf, 16'h0014));
    wr_reg(SFIA_DATA_OFS, 32'h0c0c_0003);
    wait_idle();
    chk_rd("both", SFIA_CMD_OFS, cmd(0, 0, 1, 1, 4'hf, 16'h0015));
    wr_reg(SFIA_CMD_OFS, cmd(0, 0, 0, 1, 4'hf, 16'h001e));
    wr_reg(SFIA_DATA_OFS, 32'h0c0c_0003);
    wait_idle();
    chk_rd("dec", SFIA_CMD_OFS, cmd(0, 0, 0, 1, 4'hf, 16'h001d));
    wait_q <= 4'h0;
    wr_reg(SFIA_CMD_OFS, cmd(1, 1, 1, 0, 4'hf, 16'h0008));
    wait_idle();
    chk_rd("ainc", SFIA_DATA_OFS, 32'h0a0a_0001);
    wait_idle();
    chk_rd("aidx", SFIA_CMD_OFS, cmd(0, 1, 1, 0, 4'hf, 16'h0009));
    wr_reg(SFIA_CMD_OFS, cmd(0, 1, 0, 0, 4'hf, 16'h0009));
    chk_rd("last", SFIA_DATA_OFS, 32'h0b0b_0002);
    chk_rd("noinc", SFIA_CMD_OFS, cmd(0, 1, 0, 0, 4'hf, 16'h0009));
    wr_reg(SFIA_CMD_OFS, cmd(1, 1, 0, 1, 4'hf, 16'h0009));
    wait_idle();
    chk_rd("adec", SFIA_DATA_OFS, 32'h0b0b_0002);
    wait_idle();
    chk_rd("didx", SFIA_CMD_OFS, cmd(0, 1, 0, 1, 4'hf, 16'h0008));
    wr_reg(SFIA_CMD_OFS, cmd(0, 1, 0, 0, 4'hf, 16'h0008));
    chk_rd("dlast", SFIA_DATA_OFS, 32'h0a0a_0001);
    rst_n_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    rst_n_in <= 1'b1;
    chk_rd("cmd_rst2", SFIA_CMD_OFS, 32'h0000_0000);
    chk_rd("data_rst2", SFIA_DATA_OFS, 32'h0000_0000);
    conclude();
  end
endmodule
`default_nettype wire
